// ===== verilog/dma_pkg.sv
// Constants, field layouts and enumerations of the six-channel DMA controller.
// Assumes a 32-bit classic Wishbone register port and one word-wide memory master.
package dma_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int ADR_W = 10;
  localparam int CH_W = 3;
  localparam int BURST_W = 16;
  localparam logic [31:0] ADDR_INC = 32'h0000_0004;

  // ----------------------------------------------------------------
  // Channel control word layout
  // ----------------------------------------------------------------
  localparam int CTL_W = 18;
  localparam int CTL_CYC_LSB = 0;
  localparam int CTL_RPOW_LSB = 2;
  localparam int CTL_N_LSB = 6;
  localparam int CTL_N_W = 10;
  localparam int CTL_SRC_INC = 16;
  localparam int CTL_DST_INC = 17;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] REG_ENABLE = 10'h000;
  localparam logic [ADR_W-1:0] REG_PRIO = 10'h004;
  localparam logic [ADR_W-1:0] REG_SWREQ = 10'h008;
  localparam logic [ADR_W-1:0] REG_ALT = 10'h00C;
  localparam logic [ADR_W-1:0] REG_STATUS = 10'h010;
  localparam logic [1:0] CH_REGION = 2'h1;
  localparam logic [1:0] WORD_SRC = 2'h0;
  localparam logic [1:0] WORD_DST = 2'h1;
  localparam logic [1:0] WORD_CTL = 2'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_CH-1:0] RST_CH_BITS = 6'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [CTL_W-1:0] RST_CTL = 18'h00000;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CYC_INVALID = 2'h0,
    CYC_BASIC = 2'h1,
    CYC_AUTO = 2'h2,
    CYC_PINGPONG = 2'h3
  } cycle_e;

  typedef enum logic [1:0] {
    ST_ARB = 2'h0,
    ST_READ = 2'h1,
    ST_WRITE = 2'h2,
    ST_NEXT = 2'h3
  } state_e;

endpackage

// ===== verilog/multichannel_dma_controller.sv
// Six-channel DMA engine: control structures, arbiter, transfer sequencer.
// Assumes a classic Wishbone master for registers and a req/ack memory slave.
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module multichannel_dma_controller (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dma_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Peripheral requests
  input wire logic sync_serial_a_tx_req,
  input wire logic sync_serial_a_rx_req,
  input wire logic sync_serial_b_tx_req,
  input wire logic sync_serial_b_rx_req,
  input wire logic serial_port_a_tx_req,
  input wire logic serial_port_a_rx_req,
  input wire logic serial_port_b_tx_req,
  input wire logic serial_port_b_rx_req,
  // Memory master
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i,
  // Completion
  output logic [dma_pkg::NUM_CH-1:0] done_o
);
  import dma_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    state_e st;
    logic [NUM_CH-1:0] en;
    logic [NUM_CH-1:0] prio;
    logic [NUM_CH-1:0] swpend;
    logic [NUM_CH-1:0] alt;
    logic [NUM_CH-1:0] autoact;
    logic [NUM_CH-1:0][1:0][31:0] src;
    logic [NUM_CH-1:0][1:0][31:0] dst;
    logic [NUM_CH-1:0][1:0][CTL_W-1:0] ctl;
    logic [CH_W-1:0] cur;
    logic [BURST_W-1:0] burst;
    logic [31:0] maddr;
    logic [31:0] mwdata;
    logic mwe;
    logic [NUM_CH-1:0] done;
    logic ack;
    logic [31:0] rdat;
  } dma_state_s;

  dma_state_s q;
  dma_state_s d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CH_W-1:0] pick_lowest(input logic [NUM_CH-1:0] v);
    pick_lowest = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick_lowest = CH_W'(i);
      end
    end
  endfunction

  function automatic cycle_e cycle_of(input logic [CTL_W-1:0] c);
    cycle_of = cycle_e'(c[CTL_CYC_LSB +: 2]);
  endfunction

  function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0] sel);
    merge_sel = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge_sel[8*b +: 8] = wdat[8*b +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NUM_CH-1:0] hwreq;
    logic [NUM_CH-1:0] elig;
    logic [CH_W-1:0] ch;
    logic s;
    logic [CTL_N_W-1:0] n;
    logic [3:0] rpow;
    logic take_wr;
    logic [CH_W-1:0] wch;
    logic walt;
    logic [1:0] wword;
    logic in_ch;
    logic [31:0] rd;
    hwreq = '0;
    elig = '0;
    ch = q.cur;
    s = q.alt[q.cur];
    n = q.ctl[q.cur][q.alt[q.cur]][CTL_N_LSB +: CTL_N_W];
    rpow = 4'h0;
    take_wr = 1'b0;
    wch = wb_adr_i[7:5];
    walt = wb_adr_i[4];
    wword = wb_adr_i[3:2];
    in_ch = 1'b0;
    rd = RST_WORD;
    d = q;
    d.done = '0;

    // Transmit and receive share their channel's request line
    hwreq[0] = sync_serial_a_tx_req | sync_serial_a_rx_req;
    hwreq[1] = sync_serial_b_tx_req | sync_serial_b_rx_req;
    hwreq[2] = serial_port_a_tx_req | serial_port_a_rx_req;
    hwreq[3] = serial_port_b_tx_req | serial_port_b_rx_req;

    // Invalid active structure never competes
    for (int c = 0; c < NUM_CH; c++) begin
      elig[c] = q.en[c] & (cycle_of(q.ctl[c][q.alt[c]]) != CYC_INVALID)
                & (hwreq[c] | q.swpend[c] | q.autoact[c]);
    end

    case (q.st)
      ST_ARB: begin
        if (elig != '0) begin
          if ((elig & q.prio) != '0) begin
            ch = pick_lowest(elig & q.prio);
          end else begin
            ch = pick_lowest(elig);
          end
          s = q.alt[ch];
          rpow = q.ctl[ch][s][CTL_RPOW_LSB +: 4];
          d.cur = ch;
          d.burst = 16'h0001 << rpow;
          // Trigger is consumed per burst, so basic needs a fresh one
          d.swpend[ch] = 1'b0;
          if (cycle_of(q.ctl[ch][s]) == CYC_AUTO) begin
            d.autoact[ch] = 1'b1;
          end
          d.maddr = q.src[ch][s];
          d.mwe = 1'b0;
          d.st = ST_READ;
        end
      end
      ST_READ: begin
        if (mem_ack_i) begin
          d.mwdata = mem_rdata_i;
          d.maddr = q.dst[q.cur][s];
          d.mwe = 1'b1;
          d.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (mem_ack_i) begin
          d.mwe = 1'b0;
          d.st = ST_NEXT;
        end
      end
      ST_NEXT: begin
        d.st = ST_ARB;
        if (n == '0) begin
          d.ctl[q.cur][s][CTL_CYC_LSB +: 2] = CYC_INVALID;
          d.done[q.cur] = 1'b1;
          d.autoact[q.cur] = 1'b0;
          if (cycle_of(q.ctl[q.cur][s]) == CYC_PINGPONG) begin
            // Other structure takes over; basic or invalid there ends it
            d.alt[q.cur] = ~s;
          end
        end else begin
          d.ctl[q.cur][s][CTL_N_LSB +: CTL_N_W] = n - 10'h001;
          if (q.ctl[q.cur][s][CTL_SRC_INC]) begin
            d.src[q.cur][s] = q.src[q.cur][s] + ADDR_INC;
          end
          if (q.ctl[q.cur][s][CTL_DST_INC]) begin
            d.dst[q.cur][s] = q.dst[q.cur][s] + ADDR_INC;
          end
          d.burst = q.burst - 16'h0001;
          // Burst boundary: hand the bus back to the arbiter
          if (q.burst != 16'h0001 && q.en[q.cur]) begin
            d.maddr = d.src[q.cur][s];
            d.st = ST_READ;
          end
        end
      end
      default: begin
        d.st = ST_ARB;
      end
    endcase

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    take_wr = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
    in_ch = (wb_adr_i[9:8] == CH_REGION) && (wch < CH_W'(NUM_CH)) && (wword != 2'h3);

    if (wb_adr_i == REG_ENABLE) begin
      rd = {26'h0, q.en};
    end else if (wb_adr_i == REG_PRIO) begin
      rd = {26'h0, q.prio};
    end else if (wb_adr_i == REG_SWREQ) begin
      rd = {26'h0, q.swpend};
    end else if (wb_adr_i == REG_ALT) begin
      rd = {26'h0, q.alt};
    end else if (wb_adr_i == REG_STATUS) begin
      rd = {18'h0, q.autoact, 1'b0, q.cur, 2'h0, q.st};
    end else if (in_ch && wword == WORD_SRC) begin
      rd = q.src[wch][walt];
    end else if (in_ch && wword == WORD_DST) begin
      rd = q.dst[wch][walt];
    end else if (in_ch && wword == WORD_CTL) begin
      rd = {14'h0, q.ctl[wch][walt]};
    end
    if (d.ack) begin
      d.rdat = rd;
    end

    // Writes land at the edge that completes the bus cycle
    if (take_wr) begin
      if (wb_adr_i == REG_ENABLE) begin
        d.en = NUM_CH'(merge_sel({26'h0, q.en}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == REG_PRIO) begin
        d.prio = NUM_CH'(merge_sel({26'h0, q.prio}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == REG_SWREQ) begin
        // Or-in after the grant clear, so a trigger never gets lost
        if (wb_sel_i[0]) begin
          d.swpend = d.swpend | wb_dat_i[NUM_CH-1:0];
        end
      end else if (wb_adr_i == REG_ALT) begin
        d.alt = NUM_CH'(merge_sel({26'h0, q.alt}, wb_dat_i, wb_sel_i));
      end else if (in_ch && wword == WORD_SRC) begin
        d.src[wch][walt] = merge_sel(q.src[wch][walt], wb_dat_i, wb_sel_i);
      end else if (in_ch && wword == WORD_DST) begin
        d.dst[wch][walt] = merge_sel(q.dst[wch][walt], wb_dat_i, wb_sel_i);
      end else if (in_ch && wword == WORD_CTL) begin
        d.ctl[wch][walt] = CTL_W'(merge_sel({14'h0, q.ctl[wch][walt]}, wb_dat_i,
                                            wb_sel_i));
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.st <= ST_ARB;
      q.en <= RST_CH_BITS;
      q.prio <= RST_CH_BITS;
      q.swpend <= RST_CH_BITS;
      q.alt <= RST_CH_BITS;
      q.autoact <= RST_CH_BITS;
      q.src <= '0;
      q.dst <= '0;
      q.ctl <= '0;
      q.cur <= '0;
      q.burst <= '0;
      q.maddr <= RST_WORD;
      q.mwdata <= RST_WORD;
      q.mwe <= 1'b0;
      q.done <= RST_CH_BITS;
      q.ack <= 1'b0;
      q.rdat <= RST_WORD;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign mem_req_o = (q.st == ST_READ) || (q.st == ST_WRITE);
  assign mem_we_o = q.mwe;
  assign mem_addr_o = q.maddr;
  assign mem_wdata_o = q.mwdata;
  assign done_o = q.done;

endmodule // multichannel_dma_controller

`default_nettype wire

// ===== testbench/dma_monitor.sv
// Checker on the DMA controller's ports, bound to every instance.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dma_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i,
  input wire logic [5:0] done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  a_done_one_cycle: assert property (done_o != 6'h00 |=> (done_o & $past(done_o)) == 6'h00)
    else $error("done pulse too long");
  a_done_one_channel: assert property ($onehot0(done_o))
    else $error("two channels done at once");
  a_done_after_write: assert property (done_o != 6'h00 |-> $past(mem_req_o && mem_we_o && mem_ack_i, 2))
    else $error("done without final write");
  a_mem_req_held: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_we_o) && $stable(mem_addr_o) && $stable(mem_wdata_o))
    else $error("memory request changed before ack");
  a_read_then_write: assert property (mem_req_o && !mem_we_o && mem_ack_i |=>
    mem_req_o && mem_we_o && mem_wdata_o == $past(mem_rdata_i))
    else $error("write does not carry read word");
  a_gap_after_write: assert property (mem_req_o && mem_we_o && mem_ack_i |=> !mem_req_o)
    else $error("no idle cycle after write");
endmodule // dma_monitor
bind multichannel_dma_controller dma_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .done_o);
`default_nettype wire

// ===== testbench/mem_model.sv
// Word memory behind the DMA master port, answering after a random wait.
// Assumes the master holds each request until it sees ack.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock
  input wire logic clk_i,
  // Master side
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic ack_o
);
  logic [31:0] store [logic [31:0]];
  logic [31:0] wlog [$];
  int wait_q = 0;
  initial begin
    rdata_o = 32'h0;
    ack_o = 1'b0;
  end
  // Bus inverts its stale word after every answer, read or write, so no read can pass by luck
  always @(posedge clk_i) begin
    if (ack_o) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      wait_q <= $urandom_range(2);
    end else if (req_i && wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (req_i) begin
      ack_o <= 1'b1;
      if (we_i) begin
        store[addr_i] = wdata_i;
        wlog.push_back(addr_i);
      end else begin
        rdata_o <= {addr_i[15:0], ~addr_i[15:0]};
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench: registers over Wishbone, channel cycles against a memory model.
// Assumes the controller's register map and the model's data pattern.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dma_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, mreq, mwe, mack;
  logic [ADR_W-1:0] adr;
  logic [31:0] wdat, rdat, dout, maddr, mwdat, mrdat;
  logic [7:0] hw;
  logic [5:0] done;
  logic [31:0] sbase [6];
  logic [31:0] dbase [6];
  int bad_count = 0;
  int comparisons = 0;
  int n;
  multichannel_dma_controller uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .sync_serial_a_tx_req(hw[0]), .sync_serial_a_rx_req(hw[1]),
    .sync_serial_b_tx_req(hw[2]), .sync_serial_b_rx_req(hw[3]), .serial_port_a_tx_req(hw[4]),
    .serial_port_a_rx_req(hw[5]), .serial_port_b_tx_req(hw[6]), .serial_port_b_rx_req(hw[7]),
    .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwdat),
    .mem_rdata_i(mrdat), .mem_ack_i(mack), .done_o(done));
  mem_model mem (.clk_i, .req_i(mreq), .we_i(mwe), .addr_i(maddr), .wdata_i(mwdat),
    .rdata_o(mrdat), .ack_o(mack));
  function automatic int ca(input int c, input int alt);
    return 32'h108 + c * 32'h20 + alt * 32'h10;
  endfunction
  // Word the memory model returns for a read of address a
  function automatic logic [31:0] exp_word(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input int a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ADR_W'(a);
    wdat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t >= 20) cmp(32'h0, 32'h1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic setup(input int c, input logic [1:0] ty, input int r, input int k);
    sbase[c] = $urandom & 32'h0FFF_FFFC;
    dbase[c] = 32'h8000_0000 + c * 32'h1000;
    wb(1'b1, ca(c, 0) - 8, sbase[c]);
    wb(1'b1, ca(c, 0) - 4, dbase[c]);
    wb(1'b1, ca(c, 0), 32'h3_0000 | 32'((k - 1) << 6 | r << 2) | 32'(ty));
  endtask
  task automatic wait_done(input int c);
    int t;
    t = 0;
    while (done[c] !== 1'b1 && t < 3000) begin
      @(posedge clk_i);
      t++;
    end
    cmp(32'(t < 3000), 32'h1);
  endtask
  task automatic chk(input int c, input int k);
    for (int i = 0; i < k; i++) begin
      cmp(mem.store[dbase[c] + 32'(4 * i)], exp_word(sbase[c] + 32'(4 * i)));
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #600_000;
    cmp(32'h0, 32'h1);
    report_and_stop();
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat, hw} = '0;
    void'($urandom(32'h807B));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, REG_STATUS, 0);
    cmp(rdat, 32'h0);
    n = $urandom & 32'h3F;
    wb(1'b1, REG_ENABLE, n);
    wb(1'b0, REG_ENABLE, 0);
    cmp(rdat, n);
    wb(1'b0, 10'h3FC, 0);
    cmp(rdat, 32'h0);
    wb(1'b1, REG_ENABLE, 32'h3F);
    $display("registers done");
    n = $urandom_range(8, 1);
    setup(4, CYC_AUTO, $urandom_range(2), n);
    wb(1'b1, REG_SWREQ, 32'h10);
    wait_done(4);
    chk(4, n);
    wb(1'b0, ca(4, 0), 0);
    cmp(rdat[1:0], CYC_INVALID);
    $display("auto done");
    for (int c = 0; c < 4; c++) begin
      n = $urandom_range(4, 1);
      setup(c, CYC_BASIC, 3, n);
      hw[2 * c + c % 2] <= 1'b1;
      wait_done(c);
      hw <= 8'h00;
      chk(c, n);
    end
    $display("hardware requests done");
    setup(5, CYC_BASIC, 0, 2);
    wb(1'b1, REG_SWREQ, 32'h20);
    repeat (40) @(posedge clk_i);
    wb(1'b0, ca(5, 0), 0);
    cmp(rdat, 32'h3_0001);
    wb(1'b1, REG_SWREQ, 32'h20);
    wait_done(5);
    chk(5, 2);
    $display("basic done");
    // Low-priority channels keep R at zero so the high one is not starved
    for (int k = 0; k < 2; k++) begin
      setup(k, CYC_AUTO, 0, 1);
      setup(3 - k, CYC_AUTO, 0, 1);
      wb(1'b1, REG_PRIO, k ? 32'h0 : 32'h8);
      mem.wlog.delete();
      wb(1'b1, REG_SWREQ, k ? 32'h6 : 32'h9);
      wait_done(k ? 2 : 0);
      cmp(mem.wlog[0], dbase[k ? 1 : 3]);
    end
    $display("priority done");
    setup(4, CYC_PINGPONG, 0, 1);
    wb(1'b1, REG_SWREQ, 32'h10);
    wait_done(4);
    wb(1'b0, REG_ALT, 0);
    cmp(rdat[4], 1'b1);
    mem.wlog.delete();
    wb(1'b1, REG_SWREQ, 32'h10);
    repeat (40) @(posedge clk_i);
    cmp(mem.wlog.size(), 32'h0);
    // Trigger left pending above starts the freshly prepared alternate
    sbase[4] = sbase[4] + 32'h40;
    dbase[4] = dbase[4] + 32'h40;
    wb(1'b1, ca(4, 1) - 8, sbase[4]);
    wb(1'b1, ca(4, 1) - 4, dbase[4]);
    wb(1'b1, ca(4, 1), 32'h3_0001);
    wait_done(4);
    cmp(mem.wlog[0], dbase[4]);
    chk(4, 1);
    $display("ping-pong done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
